// [shared/sysctl_pkg.sv]
package sysctl_pkg;
	// i/o port addresses
	localparam logic [15:0] PORT_CTRL_B = 16'h0061;
	localparam logic [15:0] PORT_RAM_ADDR = 16'h0070;
	localparam logic [15:0] PORT_RAM_DATA = 16'h0071;
	localparam logic [15:0] PORT_ARB = 16'h0090;
	localparam logic [15:0] PORT_CTRL_A = 16'h0092;
	// control port b fields
	localparam int B_PARITY = 7;
	localparam int B_TICK_CLR = 7;
	localparam int B_CHANNEL = 6;
	localparam int B_TIMER2_OUT = 5;
	localparam int B_REFRESH = 4;
	localparam int B_CHK_DIS = 3;
	localparam int B_PAR_DIS = 2;
	localparam int B_SPK_EN = 1;
	localparam int B_T2_GATE = 0;
	// control port a fields
	localparam int A_LIGHT_HI = 7;
	localparam int A_LIGHT_LO = 6;
	localparam int A_WATCHDOG = 4;
	localparam int A_LOCK = 3;
	localparam int A_GATE20 = 1;
	localparam int A_ALT_RESET = 0;
	// other fields
	localparam int ADDR_MASK_BIT = 7;
	localparam int ARB_FREEZE_BIT = 6;
	// reset values
	localparam logic RST_MASK = 1'b1;
	localparam logic RST_PAR_DIS = 1'b1;
	localparam logic RST_CHK_DIS = 1'b0;
	localparam logic [7:0] RST_PW_BYTE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;
	// password area in the clock ram
	localparam logic [6:0] PW_BASE = 7'h38;
	localparam int PW_BYTES = 8;
	// alternate reset timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int ALT_DELAY_NS = 6720;
	localparam int ALT_PULSE_MIN_NS = 100;
	localparam int ALT_PULSE_MAX_NS = 125;
	localparam int ALT_TOTAL_NS = 13400;
	localparam int ALT_DELAY_CYC = (ALT_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ALT_PULSE_CYC = (ALT_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ALT_PULSE_MAX_CYC = ALT_PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int ALT_TOTAL_CYC = ALT_TOTAL_NS / CLK_PERIOD_NS;
	localparam int ALT_CNT_W = 12;
endpackage

// [shared/misc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface misc_link_if;
	logic alt_start;
	logic alt_pulse;
	logic alt_busy;
	logic pw_wr;
	logic [2:0] pw_index;
	logic [7:0] pw_wdata;
	logic [7:0] pw_rdata;
	modport ctrl(output alt_start, input alt_pulse, input alt_busy,
		output pw_wr, output pw_index, output pw_wdata, input pw_rdata);
	modport timer(input alt_start, output alt_pulse, output alt_busy);
	modport store(input pw_wr, input pw_index, input pw_wdata,
		output pw_rdata);
endinterface
`default_nettype wire

// [src/alt_reset_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module alt_reset_timer
	import sysctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	misc_link_if.timer link
);
	localparam logic [ALT_CNT_W-1:0] DELAY_END = ALT_CNT_W'(ALT_DELAY_CYC);
	localparam logic [ALT_CNT_W-1:0] PULSE_END =
		ALT_CNT_W'(ALT_DELAY_CYC + ALT_PULSE_CYC);

	logic [ALT_CNT_W-1:0] count_reg;
	logic busy_reg;
	logic pulse_reg;

	// one run: wait the least delay, then a pulse of the least width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else if (ce) begin
			if (!busy_reg) begin
				count_reg <= '0;
				busy_reg <= link.alt_start;
				pulse_reg <= 1'b0;
			end else begin
				count_reg <= count_reg + 1'b1;
				if (count_reg == DELAY_END - 1'b1)
					pulse_reg <= 1'b1;
				if (count_reg == PULSE_END - 1'b1) begin
					pulse_reg <= 1'b0;
					busy_reg <= 1'b0;
				end
			end
		end
	end

	assign link.alt_pulse = pulse_reg;
	assign link.alt_busy = busy_reg;
endmodule
`default_nettype wire

// [src/password_store.sv]
`timescale 1ns/1ps
`default_nettype none
module password_store
	import sysctl_pkg::*;
#(
	parameter int BYTES = PW_BYTES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	misc_link_if.store link
);
	logic [7:0] bytes_reg [BYTES];

	// bytes come up as 00 only at power-on; lock gating is upstream
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BYTES; i++)
				bytes_reg[i] <= RST_PW_BYTE;
		end else if (ce && link.pw_wr) begin
			bytes_reg[link.pw_index] <= link.pw_wdata;
		end
	end

	assign link.pw_rdata = bytes_reg[link.pw_index];
endmodule
`default_nettype wire

// [src/system_control_ports_nmi.sv]
`timescale 1ns/1ps
`default_nettype none
module system_control_ports_nmi
	import sysctl_pkg::*;
(
	// clock, enable and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sys_reset,
	// host i/o port bus, one strobe cycle per access
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// nmi sources, latched on any ce cycle they are high; parity and channel only while their disable bit is clear
	input wire logic parity_error,
	input wire logic channel_check,
	input wire logic channel_timeout,
	input wire logic watchdog_timeout,
	// board levels and pulses read back or passed through
	input wire logic timer2_out,
	input wire logic refresh_request,
	input wire logic kbc_gate_twenty,
	// nmi and arbitration
	output logic nmi_request,
	output logic arb_freeze,
	// pins driven from the port bits
	output logic timer_tick_request_clear,
	output logic speaker_data_enable,
	output logic timer2_gate,
	output logic disk_light,
	output logic addr_line_twenty_gate,
	output logic cpu_reset_pulse,
	output logic password_locked
);
	misc_link_if link();

	alt_reset_timer u_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.link(link.timer)
	);

	password_store u_store (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.link(link.store)
	);

	// port decode for the write strobes; the read path has its own case
	function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
		return a == p;
	endfunction

	// decoded write strobes, one per port
	logic wr_b, wr_a, wr_ram_addr, wr_ram_data, wr_arb;
	// address port: clock ram index and nmi mask
	logic [6:0] ram_index_reg;
	logic mask_reg;
	// port b writable bits
	logic par_dis_reg, chk_dis_reg;
	logic spk_reg, gate_reg;
	// nmi source latches and the refresh toggle
	logic parity_latch_reg, channel_latch_reg;
	logic timeout_latch_reg, watchdog_latch_reg;
	logic refresh_toggle_reg;
	// port a bits
	logic [1:0] light_reg;
	logic lock_reg;
	logic gate20_reg;
	logic alt_bit_reg;
	// combinational helpers
	logic nmi_next;
	logic in_pw_area;

	// decoded writes; each use below also qualifies them with ce, except pw_wr, which the store gates with ce
	assign wr_b = io_wr && hit(io_addr, PORT_CTRL_B);
	assign wr_a = io_wr && hit(io_addr, PORT_CTRL_A);
	assign wr_ram_addr = io_wr && hit(io_addr, PORT_RAM_ADDR);
	assign wr_ram_data = io_wr && hit(io_addr, PORT_RAM_DATA);
	assign wr_arb = io_wr && hit(io_addr, PORT_ARB);
	assign in_pw_area = ram_index_reg >= PW_BASE &&
		ram_index_reg <= PW_BASE + 7'(PW_BYTES - 1);

	// clock ram index and nmi mask share the address port; every
	// index write also rewrites the mask, so software must keep it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_index_reg <= '0;
			mask_reg <= RST_MASK;
		end else if (ce && wr_ram_addr) begin
			ram_index_reg <= io_wdata[6:0];
			mask_reg <= io_wdata[ADDR_MASK_BIT];
		end
	end

	// port b control bits; parity disable forced at power-on only
	// bit 7 is write-only and handled by the tick clear below
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			par_dis_reg <= RST_PAR_DIS;
			chk_dis_reg <= RST_CHK_DIS;
			spk_reg <= 1'b0;
			gate_reg <= 1'b0;
		end else if (ce && wr_b) begin
			par_dis_reg <= io_wdata[B_PAR_DIS];
			chk_dis_reg <= io_wdata[B_CHK_DIS];
			spk_reg <= io_wdata[B_SPK_EN];
			gate_reg <= io_wdata[B_T2_GATE];
		end
	end

	// timer tick clear is a one-cycle pulse per qualifying write
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			timer_tick_request_clear <= 1'b0;
		else if (ce)
			timer_tick_request_clear <= wr_b && io_wdata[B_TICK_CLR];
	end

	// check latches: a disable bit holds its latch clear, which is
	// how software drops a latched error; a source that is high
	// during system reset still sets, so no event is lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			parity_latch_reg <= 1'b0;
			channel_latch_reg <= 1'b0;
		end else if (ce) begin
			if (par_dis_reg)
				parity_latch_reg <= 1'b0;
			else if (parity_error)
				parity_latch_reg <= 1'b1;
			else if (sys_reset)
				parity_latch_reg <= 1'b0;
			if (chk_dis_reg)
				channel_latch_reg <= 1'b0;
			else if (channel_check)
				channel_latch_reg <= 1'b1;
			else if (sys_reset)
				channel_latch_reg <= 1'b0;
		end
	end

	// timeout latches bypass the mask and hold until system reset
	// software has no way to clear them; only a reset does
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timeout_latch_reg <= 1'b0;
			watchdog_latch_reg <= 1'b0;
		end else if (ce) begin
			if (channel_timeout)
				timeout_latch_reg <= 1'b1;
			else if (sys_reset)
				timeout_latch_reg <= 1'b0;
			if (watchdog_timeout)
				watchdog_latch_reg <= 1'b1;
			else if (sys_reset)
				watchdog_latch_reg <= 1'b0;
		end
	end

	// request level follows the enabled latches
	assign nmi_next = (!mask_reg && (parity_latch_reg ||
		channel_latch_reg)) || timeout_latch_reg || watchdog_latch_reg;

	// registered so the pin never glitches while latches change
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			nmi_request <= 1'b0;
		else if (ce)
			nmi_request <= nmi_next && !sys_reset;
	end

	// freeze starts with the nmi; a new nmi wins over a resume write
	// software must resume even after every source has gone away
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			arb_freeze <= 1'b0;
		else if (ce) begin
			if (sys_reset)
				arb_freeze <= 1'b0;
			else if (nmi_next)
				arb_freeze <= 1'b1;
			else if (wr_arb && !io_wdata[ARB_FREEZE_BIT])
				arb_freeze <= 1'b0;
		end
	end

	// refresh toggle; a request while ce is low is not counted,
	// since the enable freezes every flop of the block
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refresh_toggle_reg <= 1'b0;
		else if (ce && refresh_request)
			refresh_toggle_reg <= !refresh_toggle_reg;
	end

	// port a bits; lock survives system reset, only power-on clears it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			light_reg <= 2'b00;
			lock_reg <= 1'b0;
			gate20_reg <= 1'b0;
		end else if (ce && wr_a) begin
			light_reg <= io_wdata[A_LIGHT_HI:A_LIGHT_LO];
			if (io_wdata[A_LOCK])
				lock_reg <= 1'b1;
			gate20_reg <= io_wdata[A_GATE20];
		end
	end

	// alternate reset bit: kept while the pulse runs so it can be read
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			alt_bit_reg <= 1'b0;
		else if (ce) begin
			if (sys_reset)
				alt_bit_reg <= 1'b0;
			else if (wr_a)
				alt_bit_reg <= io_wdata[A_ALT_RESET];
		end
	end

	// start only on a rising write; a rewrite of 1 does nothing
	// the timer runs to its end even if the bit is written 0 mid-run
	assign link.alt_start = ce && wr_a && io_wdata[A_ALT_RESET] &&
		!alt_bit_reg && !sys_reset;

	// password bytes reachable only while the lock is open
	// the index wraps into three bits; in_pw_area qualifies it
	assign link.pw_wr = wr_ram_data && in_pw_area && !lock_reg;
	assign link.pw_index = 3'(ram_index_reg - PW_BASE);
	assign link.pw_wdata = io_wdata;

	// registered pin outputs
	// one stage here so every pin comes straight from a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speaker_data_enable <= 1'b0;
			timer2_gate <= 1'b0;
			disk_light <= 1'b0;
			addr_line_twenty_gate <= 1'b0;
			cpu_reset_pulse <= 1'b0;
			password_locked <= 1'b0;
		end else if (ce) begin
			speaker_data_enable <= spk_reg;
			timer2_gate <= gate_reg;
			disk_light <= |light_reg;
			addr_line_twenty_gate <= gate20_reg || kbc_gate_twenty;
			cpu_reset_pulse <= link.alt_pulse;
			password_locked <= lock_reg;
		end
	end

	// read data, one cycle after the strobe; reserved bits are zero
	// write-only and unmapped ports read all ones, like an idle bus
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			io_rdata <= 8'h00;
		else if (ce && io_rd) begin
			unique case (io_addr)
				PORT_CTRL_B: io_rdata <= {parity_latch_reg,
					channel_latch_reg, timer2_out,
					refresh_toggle_reg, chk_dis_reg,
					par_dis_reg, spk_reg, gate_reg};
				PORT_CTRL_A: io_rdata <= {light_reg, 1'b0,
					watchdog_latch_reg, lock_reg, 1'b0,
					gate20_reg, alt_bit_reg};
				PORT_RAM_DATA: io_rdata <= (in_pw_area && !lock_reg) ?
					link.pw_rdata : UNMAPPED_READ;
				default: io_rdata <= UNMAPPED_READ;
			endcase
		end
	end
endmodule
`default_nettype wire

// [tb/sysctl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sysctl_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sys_reset,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic watchdog_timeout,
	input wire logic nmi_request,
	input wire logic arb_freeze,
	input wire logic timer_tick_request_clear,
	input wire logic speaker_data_enable,
	input wire logic timer2_gate,
	input wire logic disk_light,
	input wire logic cpu_reset_pulse,
	input wire logic password_locked
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// decoded writes; ce gates every taken access
	wire logic go = ce && !sys_reset;
	wire logic wr = ce && io_wr;
	wire logic wr_a = wr && io_addr == 16'h0092;
	wire logic wr_b = wr && io_addr == 16'h0061;
	wire logic arb0 = wr && io_addr == 16'h0090 && !io_wdata[6];
	wire logic lit = io_wdata[7] || io_wdata[6];
	wdog_nmi_a: assert property (
		watchdog_timeout && go ##1 go ##1 go |=> nmi_request)
		else $error("no nmi on watchdog");
	freeze_on_nmi_a: assert property (
		$rose(nmi_request) |-> ##[0:1] arb_freeze)
		else $error("nmi without freeze");
	freeze_hold_a: assert property (
		$fell(arb_freeze) |-> $past(arb0) || $past(arb0, 2) ||
		$past(sys_reset) || $past(sys_reset, 2))
		else $error("freeze dropped on its own");
	sysrst_clear_a: assert property (
		sys_reset && ce ##1 sys_reset && ce |=> !nmi_request && !arb_freeze)
		else $error("system reset left nmi");
	tick_clear_a: assert property (
		wr_b && io_wdata[7] |-> ##[1:2] timer_tick_request_clear)
		else $error("no tick clear pulse");
	port_b_pins_a: assert property (
		wr_b |-> ##2 speaker_data_enable == $past(io_wdata[1], 2) &&
		timer2_gate == $past(io_wdata[0], 2))
		else $error("speaker pins wrong");
	disk_light_a: assert property (
		wr_a |-> ##2 disk_light == $past(lit, 2))
		else $error("disk light wrong");
	lock_sticky_a: assert property (
		password_locked |=> password_locked)
		else $error("lock cleared");
	pulse_width_a: assert property (
		$rose(cpu_reset_pulse) |-> ##24 cpu_reset_pulse ##1 !cpu_reset_pulse)
		else $error("reset pulse width wrong");
	nmi_c: cover property ($rose(nmi_request));
	pulse_c: cover property ($rose(cpu_reset_pulse));
	lock_c: cover property ($rose(password_locked));
endmodule
bind system_control_ports_nmi sysctl_chk u_chk (.clk, .rst, .ce, .sys_reset,
	.io_addr, .io_wr, .io_wdata, .watchdog_timeout, .nmi_request,
	.arb_freeze, .timer_tick_request_clear, .speaker_data_enable,
	.timer2_gate, .disk_light, .cpu_reset_pulse, .password_locked);
`default_nettype wire

// [tb/host_io_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_io_model
	import sysctl_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] io_rdata,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	// bus idle at time zero
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// one strobe cycle, launched and dropped on falling edges
	task automatic wr(input logic [15:0] a, input logic [7:0] dv);
		@(negedge clk);
		io_addr = a;
		io_wdata = dv;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
		io_wdata = ~dv; // released data never shows a stale byte
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] dv);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		dv = io_rdata;
	endtask
	// index write is always followed at once by the data port
	task automatic ram_wr(input logic [7:0] ix, input logic [7:0] dv);
		wr(PORT_RAM_ADDR, ix);
		wr(PORT_RAM_DATA, dv);
	endtask
	task automatic ram_rd(input logic [7:0] ix, output logic [7:0] dv);
		wr(PORT_RAM_ADDR, ix);
		rd(PORT_RAM_DATA, dv);
	endtask
endmodule
`default_nettype wire

// [tb/system_control_ports_nmi_test.sv]
`timescale 1ns/1ps
`default_nettype none
module system_control_ports_nmi_test
	import sysctl_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic srst = 1'b0;
	logic t2 = 1'b0;
	logic rf = 1'b0;
	logic kbc = 1'b0;
	logic [3:0] sv = 4'h0;
	logic [7:0] d, v;
	logic snap = 1'b0;
	logic [31:0] rs = 32'hADCF;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int refs = 0;
	int n, m;
	int nt = 0;
	int ticks = 0;
	wire logic [15:0] addr;
	wire logic wr, rd;
	wire logic [7:0] wdat, rdat;
	wire logic nmi, frz, spk, t2g, dl, a20, cpr, lck;
	wire logic tck;
	always #2 clk = ~clk;
	host_io_model host (.clk, .io_rdata(rdat), .io_addr(addr), .io_wr(wr),
		.io_rd(rd), .io_wdata(wdat));
	system_control_ports_nmi u_system_control_ports_nmi (.clk, .rst, .ce,
		.sys_reset(srst), .io_addr(addr), .io_wr(wr), .io_rd(rd),
		.io_wdata(wdat), .io_rdata(rdat), .parity_error(sv[0]),
		.channel_check(sv[1]), .channel_timeout(sv[2]),
		.watchdog_timeout(sv[3]), .timer2_out(t2), .refresh_request(rf),
		.kbc_gate_twenty(kbc), .nmi_request(nmi), .arb_freeze(frz),
		.timer_tick_request_clear(tck), .speaker_data_enable(spk),
		.timer2_gate(t2g), .disk_light(dl), .addr_line_twenty_gate(a20),
		.cpu_reset_pulse(cpr), .password_locked(lck));
	// refresh every 37 cycles; tick clear pulses counted mid-cycle
	always @(negedge clk) begin
		rf <= (cyc % 37 == 5);
		if (tck === 1'b1)
			ticks++;
	end
	// snap is the toggle a read will see; ce freezes both
	always @(posedge clk) begin
		cyc++;
		if (rd && ce)
			snap = refs[0];
		if (rf && !rst && ce)
			refs++;
		if (cyc > 10000) begin
			n_mismatch++;
			close_out;
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string s, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic pin(input string s, input logic e, g);
		chk(s, {7'h00, e}, {7'h00, g});
	endtask
	task automatic rdc(input string s, input logic [15:0] a, logic [7:0] e);
		host.rd(a, d);
		chk(s, e, d);
	endtask
	task automatic rdb(input logic [1:0] hi, input logic [3:0] lo);
		host.rd(PORT_CTRL_B, d);
		chk("port b", {hi, t2, snap, lo}, d);
	endtask
	// writes wait out the two-edge path to the pins
	task automatic w(input logic [15:0] a, input logic [7:0] dv);
		if (a == PORT_CTRL_B && dv[7])
			nt++;
		host.wr(a, dv);
		repeat (2) @(negedge clk);
	endtask
	task automatic src(input int k);
		sv = 4'h1 << k;
		@(negedge clk);
		sv = 4'h0;
		repeat (4) @(negedge clk);
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// main sequence; masked sources must stay quiet after power-on
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		rdc("port a", PORT_CTRL_A, 8'h00);
		src(0);
		src(1);
		rdb(2'b01, 4'b0100);
		pin("nmi", 1'b0, nmi);
		fin("reset");
		for (int i = 0; i < 6; i++) begin
			rs = xs(rs);
			t2 = rs[8];
			v = {rs[7:4], 2'b10, rs[1:0]};
			w(PORT_CTRL_B, v);
			rdb(2'b00, {2'b10, v[1:0]});
			pin("speaker", v[1], spk);
			pin("gate", v[0], t2g);
		end
		fin("port b");
		src(0);
		rdb(2'b10, {2'b10, v[1:0]});
		pin("nmi", 1'b0, nmi);
		host.ram_rd(8'h00, d);
		chk("ram data", 8'hFF, d);
		repeat (4) @(negedge clk);
		pin("nmi", 1'b1, nmi);
		pin("freeze", 1'b1, frz);
		w(PORT_CTRL_B, 8'h0C);
		w(PORT_CTRL_B, 8'h08);
		pin("nmi", 1'b0, nmi);
		pin("freeze", 1'b1, frz);
		w(PORT_ARB, 8'h00);
		pin("freeze", 1'b0, frz);
		w(PORT_CTRL_B, 8'h00);
		src(1);
		pin("nmi", 1'b1, nmi);
		rdb(2'b01, 4'b0000);
		w(PORT_CTRL_B, 8'h88);
		rdb(2'b00, 4'b1000);
		pin("nmi", 1'b0, nmi);
		w(PORT_ARB, 8'h00);
		fin("parity and channel");
		host.ram_rd(8'h80, d);
		for (int k = 2; k < 4; k++) begin
			src(k);
			pin("nmi", 1'b1, nmi);
			rdc("port a", PORT_CTRL_A, k == 3 ? 8'h10 : 8'h00);
			srst = 1'b1;
			repeat (2) @(negedge clk);
			srst = 1'b0;
			repeat (2) @(negedge clk);
			pin("nmi", 1'b0, nmi);
			pin("freeze", 1'b0, frz);
		end
		fin("timeouts");
		for (int k = 0; k < 2; k++) begin
			kbc = k[0];
			w(PORT_CTRL_A, 8'h66);
			rdc("port a", PORT_CTRL_A, 8'h42);
			pin("light", 1'b1, dl);
			pin("a20", 1'b1, a20);
			w(PORT_CTRL_A, 8'h00);
			pin("light", 1'b0, dl);
			pin("a20", k[0], a20);
		end
		ce = 1'b0;
		host.wr(PORT_CTRL_A, 8'hC1);
		ce = 1'b1;
		rdc("frozen", PORT_CTRL_A, 8'h00);
		pin("light", 1'b0, dl);
		rdc("ram addr", PORT_RAM_ADDR, 8'hFF);
		host.ram_rd({1'b1, PW_BASE}, d);
		chk("pw byte", 8'h00, d);
		v = rs[7:0];
		host.ram_wr({1'b1, PW_BASE}, v);
		host.ram_rd({1'b1, PW_BASE}, d);
		chk("pw byte", v, d);
		w(PORT_CTRL_A, 8'h08);
		pin("lock", 1'b1, lck);
		w(PORT_CTRL_A, 8'h00);
		rdc("port a", PORT_CTRL_A, 8'h08);
		host.ram_rd({1'b1, PW_BASE}, d);
		chk("pw locked", 8'hFF, d);
		fin("port a");
		host.wr(PORT_CTRL_A, 8'h09);
		n = 0;
		while (cpr !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		m = 0;
		while (cpr === 1'b1 && m < 100) begin
			@(negedge clk);
			m++;
		end
		pin("delay", 1'b1, n >= ALT_DELAY_CYC);
		pin("width", 1'b1, m >= ALT_PULSE_CYC && m <= ALT_PULSE_MAX_CYC);
		pin("length", 1'b1, n + m <= ALT_TOTAL_CYC);
		rdc("port a", PORT_CTRL_A, 8'h09);
		w(PORT_CTRL_A, 8'h08);
		rdc("port a", PORT_CTRL_A, 8'h08);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rdc("port a", PORT_CTRL_A, 8'h08);
		fin("alt reset");
		chk("tick clears", 8'(nt), 8'(ticks));
		close_out;
	end
endmodule
`default_nettype wire
